// >>> core/mdsc_defs.svh
`ifndef MDSC_DEFS_SVH
`define MDSC_DEFS_SVH

// register byte offsets
`define MDSC_OFS_CTRL      12'h000
`define MDSC_OFS_STATUS    12'h004
`define MDSC_OFS_EVENT     12'h008
`define MDSC_OFS_MASK      12'h00c
`define MDSC_OFS_CHAN_BASE 12'h040

// field positions
`define MDSC_CTRL_LINK_EN  0
`define MDSC_ST_BUSY       0
`define MDSC_ST_CHAIN      1
`define MDSC_ST_PD         2
`define MDSC_ST_ARMED      3
`define MDSC_ST_BITCNT_LO  8
`define MDSC_EV_LOADED     0
`define MDSC_EV_DISCARD    1
`define MDSC_EV_CONV_DONE  2
`define MDSC_EV_W          3

// sizes
`define MDSC_CHANNELS      16
`define MDSC_CODE_W        14
`define MDSC_FRAME_BITS    5'd18
`define MDSC_CNT_MAX       5'h1f

// reset values
`define MDSC_RST_CTRL_EN   1'b1
`define MDSC_RST_MASK      3'h0
`define MDSC_RST_CODE      14'h2000

// timing
`define MDSC_CLK_HZ        10000000
`define MDSC_CONV_TIME_NS  25000
`define MDSC_CONV_CYCLES   ((`MDSC_CONV_TIME_NS * (`MDSC_CLK_HZ / 1000000) + 999) / 1000)

`endif

// >>> core/mdsc_pkg.sv
`include "mdsc_defs.svh"

package mdsc_pkg;

  typedef enum logic [1:0] {
    MDSC_MODE_LOAD = 2'b00,
    MDSC_MODE_INC  = 2'b01,
    MDSC_MODE_DEC  = 2'b10,
    MDSC_MODE_NOP  = 2'b11
  } mdsc_mode_t;

  typedef enum logic [2:0] {
    MDSC_REG_CTRL   = 3'b000,
    MDSC_REG_STATUS = 3'b001,
    MDSC_REG_EVENT  = 3'b010,
    MDSC_REG_MASK   = 3'b011,
    MDSC_REG_CHAN   = 3'b100,
    MDSC_REG_NONE   = 3'b111
  } mdsc_reg_t;

  typedef logic [`MDSC_CODE_W-1:0]        mdsc_code_t;
  typedef mdsc_code_t [`MDSC_CHANNELS-1:0] mdsc_bank_t;

  typedef struct packed {
    mdsc_mode_t  mode;
    logic [3:0]  channel_select;
    logic [11:0] word_payload;
  } mdsc_frame_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mdsc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } mdsc_apb_rsp_t;

  typedef struct packed {
    logic sync_n;
    logic sclk;
    logic din;
  } mdsc_link_in_t;

  typedef struct packed {
    logic                  sclk_s1;
    logic                  sclk_s2;
    logic                  sclk_d;
    logic                  sync_s1;
    logic                  sync_s2;
    logic                  sync_d;
    logic                  din_s1;
    logic                  din_s2;
    logic                  rstn_s1;
    logic                  rstn_s2;
    logic                  chain_s1;
    logic                  chain_s2;
    logic                  pd_s1;
    logic                  pd_s2;
    logic [17:0]           shreg;
    logic [4:0]            bitcnt;
    logic                  armed;
    logic                  dout;
    logic [8:0]            busy_cnt;
    logic                  ctrl_en;
    logic [`MDSC_EV_W-1:0] events;
    logic [`MDSC_EV_W-1:0] mask;
    logic [31:0]           prdata;
    logic                  pslverr;
    mdsc_bank_t            chan;
  } mdsc_state_t;

endpackage

// >>> core/mdsc_top.sv
`timescale 1ns/1ps
// Function
// RULE1: take serial bits only while frame sync low
// RULE2: shift bits in on serial clock falling edge
// RULE3: host keeps serial input stable at falling edge
// RULE4: serial output changes on rising serial clock
// RULE5: serial output carries shifted-through register bits
// RULE6: chain enable high selects chained mode
// RULE7: chain enable and power-down default low
// RULE8: reset pin defaults high, not in reset
// RULE9: reset pin low restores all channel codes
// RULE10: power-down high floats all sixteen outputs; the code only raises dac_power_down, and dac_code stays driven
// RULE11: busy low for whole conversion period
// RULE12: writes during busy are discarded
// RULE13: host waits for busy release before updating
// RULE14: channel codes are offset binary
// RULE15: frame is mode, channel select, payload
// RULE16: mode load, increment, decrement, or ignore
// RULE17: sync falling edge clears bit counter
// RULE18: standalone transfer after eighteenth falling edge
// RULE19: ignore link activity while sync high
`include "mdsc_defs.svh"

module mdsc_top
  import mdsc_pkg::*;
(
  // system
  input  wire logic          clock,
  input  wire logic          sys_rst,
  // register bus
  input  wire mdsc_apb_req_t apb_req,
  output mdsc_apb_rsp_t      apb_rsp,
  output logic               irq,
  // serial link pins
  input  wire mdsc_link_in_t link_in,
  output logic               dout,
  output logic               busy_n,
  // static pins
  input  wire logic          chain_enable,
  input  wire logic          power_down_in,
  input  wire logic          reset_n,
  // converter side
  output mdsc_bank_t         dac_code,
  output logic               dac_power_down
);

  localparam logic [8:0] CONV_CYCLES = 9'(`MDSC_CONV_CYCLES);

  mdsc_state_t s;
  mdsc_state_t next_s;

  function automatic mdsc_reg_t mdsc_decode(input logic [11:0] addr);
    mdsc_reg_t r;
    r = MDSC_REG_NONE;
    if (addr == `MDSC_OFS_CTRL) begin
      r = MDSC_REG_CTRL;
    end else if (addr == `MDSC_OFS_STATUS) begin
      r = MDSC_REG_STATUS;
    end else if (addr == `MDSC_OFS_EVENT) begin
      r = MDSC_REG_EVENT;
    end else if (addr == `MDSC_OFS_MASK) begin
      r = MDSC_REG_MASK;
    end else if (addr[11:6] == 6'(`MDSC_OFS_CHAN_BASE >> 6) && addr[1:0] == 2'h0) begin
      r = MDSC_REG_CHAN;
    end
    return r;
  endfunction

  // new quarter-step code for a frame; saturates at both ends of the span
  function automatic mdsc_code_t mdsc_apply(input mdsc_mode_t m, input mdsc_code_t old,
                                            input logic [11:0] amt);
    logic [14:0] sum;
    mdsc_code_t  r;
    sum = 15'(old) + 15'(amt);
    r   = old;
    unique case (m)
      MDSC_MODE_LOAD: r = {amt, 2'h0}; // RULE16
      MDSC_MODE_INC:  r = sum[14] ? 14'h3fff : sum[13:0]; // RULE16 RULE14
      MDSC_MODE_DEC:  r = (14'(amt) > old) ? 14'h0000 : old - 14'(amt); // RULE16 RULE14
      MDSC_MODE_NOP:  r = old; // RULE16
    endcase
    return r;
  endfunction

  function automatic mdsc_state_t mdsc_reset_state();
    mdsc_state_t r;
    r          = '0;
    // sclk idles high between frames, so no false edge follows reset
    r.sclk_s1  = 1'b1;
    r.sclk_s2  = 1'b1;
    r.sclk_d   = 1'b1;
    r.sync_s1  = 1'b1;
    r.sync_s2  = 1'b1;
    r.sync_d   = 1'b1;
    r.rstn_s1  = 1'b1; // RULE8
    r.rstn_s2  = 1'b1; // RULE8
    r.chain_s1 = 1'b0; // RULE7
    r.pd_s1    = 1'b0; // RULE7
    r.ctrl_en  = `MDSC_RST_CTRL_EN;
    r.mask     = `MDSC_RST_MASK;
    for (int i = 0; i < `MDSC_CHANNELS; i++) begin
      r.chan[i] = `MDSC_RST_CODE; // RULE14
    end
    return r;
  endfunction

  logic                  sclk_fall;
  logic                  sclk_rise;
  logic                  sync_fall;
  logic                  sync_rise;
  logic                  busy;
  logic                  do_xfer;
  logic [17:0]           xfer_word;
  mdsc_frame_t           fr;
  logic [`MDSC_EV_W-1:0] ev_set;
  logic [`MDSC_EV_W-1:0] ev_clr;
  mdsc_reg_t             dec;
  logic [31:0]           rd_val;
  logic                  wr_access;

  always_comb begin
    next_s    = s;
    ev_set    = '0;
    ev_clr    = '0;
    do_xfer   = 1'b0;
    xfer_word = s.shreg;
    fr        = mdsc_frame_t'(s.shreg);
    rd_val    = 32'h0000_0000;

    // pin synchronisers; only the second stage and later are looked at
    next_s.sclk_s1  = link_in.sclk;
    next_s.sclk_s2  = s.sclk_s1;
    next_s.sclk_d   = s.sclk_s2;
    next_s.sync_s1  = link_in.sync_n;
    next_s.sync_s2  = s.sync_s1;
    next_s.sync_d   = s.sync_s2;
    next_s.din_s1   = link_in.din;
    next_s.din_s2   = s.din_s1;
    next_s.rstn_s1  = reset_n;
    next_s.rstn_s2  = s.rstn_s1;
    next_s.chain_s1 = chain_enable;
    next_s.chain_s2 = s.chain_s1;
    next_s.pd_s1    = power_down_in;
    next_s.pd_s2    = s.pd_s1;

    // each sclk phase must last three clocks; the pin's top rate is out of reach
    sclk_fall = s.sclk_d & ~s.sclk_s2;
    sclk_rise = ~s.sclk_d & s.sclk_s2;
    sync_fall = s.sync_d & ~s.sync_s2;
    sync_rise = ~s.sync_d & s.sync_s2;
    busy      = (s.busy_cnt != 9'h000);

    // conversion timer
    if (busy) begin
      next_s.busy_cnt = s.busy_cnt - 9'h001; // RULE11
      if (s.busy_cnt == 9'h001) begin
        ev_set[`MDSC_EV_CONV_DONE] = 1'b1;
      end
    end

    // serial frame capture
    if (sync_fall) begin
      next_s.bitcnt = 5'h00; // RULE17
      next_s.armed  = s.ctrl_en; // RULE17
    end else if (sync_rise) begin
      // chained mode commits the last eighteen bits when sync returns high
      if (s.chain_s2 && s.armed && s.bitcnt >= `MDSC_FRAME_BITS) begin // RULE6
        if (busy) begin
          ev_set[`MDSC_EV_DISCARD] = 1'b1; // RULE12
        end else begin
          do_xfer   = 1'b1;
          xfer_word = s.shreg;
        end
      end
      next_s.armed = 1'b0;
    end else if (!s.sync_s2 && s.armed && sclk_fall) begin // RULE1 RULE19
      if (busy) begin
        // bits clocked during a conversion spoil the frame
        next_s.armed             = 1'b0; // RULE12
        ev_set[`MDSC_EV_DISCARD] = 1'b1; // RULE12
      end else begin
        next_s.shreg = {s.shreg[16:0], s.din_s2}; // RULE2 RULE3
        if (s.bitcnt != `MDSC_CNT_MAX) begin
          next_s.bitcnt = s.bitcnt + 5'h01;
        end
        if (!s.chain_s2 && s.bitcnt == `MDSC_FRAME_BITS - 5'h01) begin // RULE18 RULE6
          do_xfer      = 1'b1;
          xfer_word    = {s.shreg[16:0], s.din_s2};
          next_s.armed = 1'b0; // RULE17
        end
      end
    end

    // serial output follows the top of the shift register on rising edges
    if (!s.sync_s2 && sclk_rise) begin // RULE19
      next_s.dout = s.shreg[17]; // RULE4 RULE5
    end

    // hand a finished frame to the addressed channel
    fr = mdsc_frame_t'(xfer_word); // RULE15
    if (do_xfer && fr.mode != MDSC_MODE_NOP) begin // RULE16
      next_s.chan[fr.channel_select] = mdsc_apply(fr.mode, s.chan[fr.channel_select],
                                                  fr.word_payload); // RULE16
      ev_set[`MDSC_EV_LOADED] = 1'b1;
      if (fr.mode == MDSC_MODE_LOAD) begin
        next_s.busy_cnt = CONV_CYCLES; // RULE11
      end
    end

    // reset pin overrides any channel code update in the same cycle
    if (!s.rstn_s2) begin
      for (int i = 0; i < `MDSC_CHANNELS; i++) begin
        next_s.chan[i] = `MDSC_RST_CODE; // RULE9
      end
    end

    // register bus: answer prepared in the setup cycle, write at access
    dec = mdsc_decode(apb_req.paddr);
    unique case (dec)
      MDSC_REG_CTRL:   rd_val[`MDSC_CTRL_LINK_EN] = s.ctrl_en;
      MDSC_REG_STATUS: begin
        rd_val[`MDSC_ST_BUSY]  = busy;
        rd_val[`MDSC_ST_CHAIN] = s.chain_s2;
        rd_val[`MDSC_ST_PD]    = s.pd_s2;
        rd_val[`MDSC_ST_ARMED] = s.armed;
        rd_val[`MDSC_ST_BITCNT_LO +: 5] = s.bitcnt;
      end
      MDSC_REG_EVENT:  rd_val[`MDSC_EV_W-1:0] = s.events;
      MDSC_REG_MASK:   rd_val[`MDSC_EV_W-1:0] = s.mask;
      MDSC_REG_CHAN:   rd_val[`MDSC_CODE_W-1:0] = s.chan[apb_req.paddr[5:2]];
      MDSC_REG_NONE:   rd_val = 32'h0000_0000;
      default:         rd_val = 32'h0000_0000;
    endcase
    if (apb_req.psel && !apb_req.penable) begin
      next_s.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_val;
      next_s.pslverr = (dec == MDSC_REG_NONE) || (apb_req.pwrite && dec == MDSC_REG_CHAN);
    end
    wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;
    if (wr_access) begin
      if (dec == MDSC_REG_CTRL) begin
        next_s.ctrl_en = apb_req.pwdata[`MDSC_CTRL_LINK_EN];
      end
      if (dec == MDSC_REG_MASK) begin
        next_s.mask = apb_req.pwdata[`MDSC_EV_W-1:0];
      end
      if (dec == MDSC_REG_EVENT) begin
        ev_clr = apb_req.pwdata[`MDSC_EV_W-1:0];
      end
    end
    // a new event wins over a clear in the same cycle
    next_s.events = (s.events & ~ev_clr) | ev_set;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s <= mdsc_reset_state();
    end else begin
      s <= next_s;
    end
  end

  assign apb_rsp.prdata  = s.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = s.pslverr;
  assign irq             = |(s.events & s.mask);
  assign dout            = s.dout; // RULE5
  assign busy_n          = (s.busy_cnt == 9'h000); // RULE11
  assign dac_code        = s.chan;
  assign dac_power_down  = s.pd_s2; // RULE10

endmodule

// >>> tb/mdsc_checker.sv
`timescale 1ns/1ps
module mdsc_checker
  import mdsc_pkg::*;
(
  // system
  input wire logic          clock,
  input wire logic          sys_rst,
  // watched ports
  input wire mdsc_apb_req_t apb_req,
  input wire mdsc_apb_rsp_t apb_rsp,
  input wire mdsc_link_in_t link_in,
  input wire logic          dout,
  input wire logic          busy_n,
  input wire logic          power_down_in,
  input wire logic          reset_n,
  input wire mdsc_bank_t    dac_code,
  input wire logic          dac_power_down
);
  logic [8:0] low_cnt;
  always_ff @(posedge clock) begin
    low_cnt <= (sys_rst || busy_n) ? 9'h000 : low_cnt + 9'h001;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_rstn_low;
    (!reset_n)[*3];
  endsequence
  AST_BUSY_LEN: assert property ($rose(busy_n) |-> low_cnt == 9'h0fa)
    else $error("busy length");
  AST_BUSY_FREEZE: assert property ((!busy_n && reset_n)[*5] |-> $stable(dac_code))
    else $error("code moved in busy");
  AST_IDLE_CODE: assert property ((link_in.sync_n && reset_n)[*8] |-> $stable(dac_code))
    else $error("code moved idle");
  AST_DOUT_RISE: assert property ($changed(dout) |->
    link_in.sclk && $past(link_in.sclk, 2)) else $error("dout moved");
  AST_PD_ON: assert property ($rose(power_down_in) |-> ##[1:4] dac_power_down)
    else $error("pd on");
  AST_PD_OFF: assert property ($fell(power_down_in) |-> ##[1:4] !dac_power_down)
    else $error("pd off");
  AST_RSTN: assert property (s_rstn_low |-> ##[0:3] dac_code == {16{14'h2000}})
    else $error("codes not reset");
  AST_SLVERR: assert property (apb_req.psel && !apb_req.penable && apb_req.pwrite
    && apb_req.paddr[11:6] == 6'h01 |=> apb_rsp.pslverr) else $error("chan write taken");
endmodule
bind mdsc_top mdsc_checker i_mdsc_checker (.clock, .sys_rst, .apb_req, .apb_rsp, .link_in,
  .dout, .busy_n, .power_down_in, .reset_n, .dac_code, .dac_power_down);

// >>> tb/mdsc_host.sv
`timescale 1ns/1ps
module mdsc_host
  import mdsc_pkg::*;
(
  // system
  input  wire logic     clock,
  // device side
  input  wire logic     busy_n,
  input  wire logic     dout,
  output mdsc_link_in_t link,
  output logic [35:0]   rx
);
  initial begin
    link = '{1'b1, 1'b1, 1'b0};
    rx = '0;
  end
  // sclk idles high; high 5 clocks, low 3, so dout has settled before sampling
  task automatic send(input logic [35:0] w, input int n, input bit wait_b);
    if (wait_b) begin
      for (int k = 0; k < 400 && busy_n !== 1'b1; k++) @(posedge clock);
    end
    repeat (4) @(posedge clock);
    link.sync_n <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = n - 1; i >= 0; i--) begin
      link.din <= w[i];
      repeat (5) @(posedge clock);
      rx <= {rx[34:0], dout};
      link.sclk <= 1'b0;
      repeat (3) @(posedge clock);
      link.sclk <= 1'b1;
    end
    repeat (6) @(posedge clock);
    link.sync_n <= 1'b1;
    link.din <= ~link.din;
  endtask
  // clock pulses with sync high; the device must not move
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      link.din <= ~link.din;
      repeat (4) @(posedge clock);
      link.sclk <= 1'b0;
      repeat (3) @(posedge clock);
      link.sclk <= 1'b1;
    end
  endtask
endmodule

// >>> tb/mdsc_top_test.sv
`timescale 1ns/1ps
module mdsc_top_test
  import mdsc_pkg::*;
;
  logic          clock, sys_rst, irq, dout, busy_n, dac_power_down, err;
  logic          chain_enable, power_down_in, reset_n;
  logic [31:0]   rd;
  logic [35:0]   rx;
  mdsc_apb_req_t apb_req;
  mdsc_apb_rsp_t apb_rsp;
  mdsc_link_in_t link;
  mdsc_bank_t    dac_code;
  int            fails, compares;
  mdsc_top i_mdsc_top (.clock, .sys_rst, .apb_req, .apb_rsp, .irq, .link_in(link), .dout,
    .busy_n, .chain_enable, .power_down_in, .reset_n, .dac_code, .dac_power_down);
  mdsc_host i_mdsc_host (.clock, .busy_n, .dout, .link, .rx);
  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do @(posedge clock); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(negedge clock);
  endtask
  task automatic frame(input logic [1:0] m, input logic [3:0] c, input logic [11:0] p,
                       input bit w);
    i_mdsc_host.send({18'h0, m, c, p}, 18, w);
  endtask
  task automatic results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    check("ctrl", rd, 32'h1);
    apb(1'b0, 12'h100, 32'h0);
    check("unmapped", 32'(err), 32'h1);
    apb(1'b1, 12'h044, 32'h5);
    check("ro", 32'(err), 32'h1);
    check("ch1", 32'(dac_code[1]), 32'h2000);
    apb(1'b1, 12'h000, 32'h0);
    frame(2'b00, 4'h5, 12'h001, 1'b1);
    check("disarmed", 32'(dac_code[5]), 32'h2000);
    apb(1'b1, 12'h000, 32'h1);
  endtask
  task automatic t_busy;
    apb(1'b1, 12'h00c, 32'h7);
    frame(2'b00, 4'hf, 12'hfff, 1'b1);
    check("ch15", 32'(dac_code[15]), 32'h3ffc);
    check("busy", 32'(busy_n), 32'h0);
    check("irq", 32'(irq), 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    check("status", rd, 32'h0000_1201);
    frame(2'b00, 4'h0, 12'h123, 1'b0);
    check("ch0", 32'(dac_code[0]), 32'h2000);
    apb(1'b1, 12'h00c, 32'h0);
    check("mask", 32'(irq), 32'h0);
    for (int n = 0; n < 400 && busy_n !== 1'b1; n++) @(posedge clock);
    apb(1'b0, 12'h008, 32'h0);
    check("ev", rd, 32'h7);
    apb(1'b1, 12'h008, 32'h7);
    apb(1'b0, 12'h008, 32'h0);
    check("w1c", rd, 32'h0);
  endtask
  task automatic t_modes;
    logic [1:0]  m [5] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b10};
    logic [11:0] p [5] = '{12'h001, 12'h00a, 12'h003, 12'h555, 12'hfff};
    logic [13:0] e [5] = '{14'h0004, 14'h000e, 14'h000b, 14'h000b, 14'h0000};
    for (int i = 0; i < 5; i++) begin
      frame(m[i], 4'h1, p[i], 1'b1);
      check("mode", 32'(dac_code[1]), 32'(e[i]));
    end
    i_mdsc_host.stray(3);
    apb(1'b0, 12'h004, 32'h0);
    check("idle bits", rd, 32'h0000_1200);
    check("idle code", 32'(dac_code[1]), 32'h0);
  endtask
  task automatic t_pins;
    power_down_in <= 1'b1;
    repeat (6) @(posedge clock);
    check("pd", 32'(dac_power_down), 32'h1);
    power_down_in <= 1'b0;
    repeat (6) @(posedge clock);
    check("pd", 32'(dac_power_down), 32'h0);
    reset_n <= 1'b0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    check("rst", 32'(dac_code[1]), 32'h2000);
    check("rst15", 32'(dac_code[15]), 32'h2000);
  endtask
  task automatic t_chain;
    chain_enable <= 1'b1;
    repeat (4) @(posedge clock);
    i_mdsc_host.send({2'b00, 4'h3, 12'habc, 2'b00, 4'h2, 12'h123}, 36, 1'b1);
    repeat (8) @(posedge clock);
    check("ch2", 32'(dac_code[2]), 32'h048c);
    check("ch3", 32'(dac_code[3]), 32'h2000);
    check("dout", 32'(rx[17:0]), 32'h03abc);
    chain_enable <= 1'b0;
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    sys_rst = 1'b1;
    apb_req = '0;
    chain_enable = 1'b0;
    power_down_in = 1'b0;
    reset_n = 1'b1;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    t_regs();
    t_busy();
    t_modes();
    t_pins();
    t_chain();
    results();
  end
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    results();
  end
endmodule
